// file: common/irq_prio_pkg.sv
// Package for the interrupt priority unit: channel map, vectors, register map.
// Assumes 128 vector slots of two bytes each above an 8-bit vector base page.
package irq_prio_pkg;
    localparam int N_CH = 128;
    localparam int CH_W = 7;
    // Channel index is vector offset divided by two
    localparam logic [6:0] CH_SPUR = 7'h08;
    localparam logic [6:0] CH_MASK_LO = 7'h0D;
    localparam logic [6:0] CH_IRQ = 7'h79;
    // Low vector offsets of non-maskable and spurious sources
    localparam logic [7:0] OFS_TRAP = 8'hF8;
    localparam logic [7:0] OFS_SWI = 8'hF6;
    localparam logic [7:0] OFS_SYS = 8'h12;
    localparam logic [7:0] OFS_COP_AV = 8'h16;
    localparam logic [7:0] OFS_CPU_AV = 8'h14;
    localparam logic [7:0] OFS_NMI = 8'hF4;
    localparam logic [7:0] OFS_SPUR = 8'h10;
    // Fixed reset vectors, independent of the base
    localparam logic [15:0] VEC_RST_EXT = 16'hFFFE;
    localparam logic [15:0] VEC_RST_CLKMON = 16'hFFFC;
    localparam logic [15:0] VEC_RST_WDOG = 16'hFFFA;
    // Reset values and fields
    localparam logic [2:0] RST_LEVEL = 3'h1;
    localparam logic [7:0] SPUR_CFG = 8'h07;
    localparam logic [7:0] VBASE_RST = 8'hFF;
    localparam logic [2:0] XPRIO_RST = 3'h1;
    localparam int CFG_ROUTE_BIT = 7;
    // Register byte offsets
    localparam logic [7:0] A_VBASE = 8'h00;
    localparam logic [7:0] A_CFADDR = 8'h04;
    localparam logic [7:0] A_CFDATA = 8'h08;
    localparam logic [7:0] A_XPRIO = 8'h0C;
    localparam logic [7:0] A_STATUS = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Channel owns a configuration entry
    function automatic logic is_cfg(input logic [6:0] ch);
        return (ch >= CH_MASK_LO) && (ch <= CH_IRQ);
    endfunction : is_cfg

    // The IRQ pin channel cannot go to the coprocessor
    function automatic logic routable(input logic [6:0] ch);
        return is_cfg(ch) && (ch != CH_IRQ);
    endfunction : routable

    function automatic logic is_mapped(input logic [7:0] a);
        return a == A_VBASE || a == A_CFADDR || a == A_CFDATA || a == A_XPRIO || a == A_STATUS;
    endfunction : is_mapped
endpackage : irq_prio_pkg

// file: rtl/irq_level_sync.sv
// Two-stage synchroniser for levels arriving from outside the clock domain.
// Assumes each bit is a slow level; no bus coherence between bits.
`timescale 1ns/1ps
module irq_level_sync #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;

    // First stage feeds only the second one
    always_ff @(posedge clk) begin
        stage1 <= d;
        stage2 <= stage1;
    end

    assign q = stage2;
endmodule : irq_level_sync

// file: rtl/irq_prio_decoder.sv
// Priority decoder: picks the highest nonzero level, ties to the higher index.
// Assumes levels arrive packed three bits per channel, channel 0 lowest.
`timescale 1ns/1ps
module irq_prio_decoder #(
    parameter int N = 128,
    parameter int IW = 7
) (
    input wire logic [3*N-1:0] levels,
    output logic found,
    output logic [IW-1:0] win,
    output logic [2:0] win_level
);
    // Ascending scan with >= lets a later equal level take over
    always_comb begin
        found = 1'b0;
        win = '0;
        win_level = 3'h0;
        for (int i = 0; i < N; i++) begin
            if (levels[3*i +: 3] != 3'h0 && levels[3*i +: 3] >= win_level) begin
                found = 1'b1;
                win = IW'(i);
                win_level = levels[3*i +: 3];
            end
        end
    end
endmodule : irq_prio_decoder

// file: rtl/interrupt_priority_unit.sv
// Interrupt priority unit: routes channels to CPU or coprocessor, supplies vectors.
// Assumes requests and CPU status arrive on CLK_SYS; pins and reset causes do not.
//
// Functional notes
// - Reset: maskable channels up to IRQ enabled, CPU-routed, level one.
// - Non-maskable and spurious sources are never disabled, always CPU, fixed order.
// - Level zero disables a maskable channel for both targets.
// - Equal levels resolve to the higher vector address.
// - CPU gets a direct channel request only if CPU-routed, nonzero, above current level.
// - Maskable CPU requests wait on mask flag or pending non-maskable events.
// - Non-maskable wins always and leaves the current level unchanged.
// - Vector fetch loads the new level from the winning CPU channel.
// - Route bit set sends the channel to the coprocessor at its level.
// - Coprocessor flags raise CPU vector base plus twice highest channel.
// - Coprocessor-raised CPU requests share one level; higher vector wins.
// - Two independent decoders: one for CPU, one for coprocessor.
// - Coprocessor gets a one-bit priority: top bit of the channel level.
// - Vector is computed at fetch time from what wins then.
// - Nothing qualifying at fetch returns the spurious vector.
// - Three reset types: external/power/voltage/address, clock monitor, watchdog.
// - Level field: zero disabled, one to seven rising, seven highest.
// - Reset vectors fixed at FFFE, FFFC, FFFA in that priority.
`timescale 1ns/1ps
module interrupt_priority_unit
    import irq_prio_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic [N_CH-1:0] IRQ_REQ,
    input wire logic [N_CH-1:0] COPROC_FLAGS,
    input wire logic COPROC_GIE,
    input wire logic MASK_FLAG,
    input wire logic [2:0] CUR_LEVEL,
    input wire logic TRAP_REQ,
    input wire logic SWI_REQ,
    input wire logic DEBUG_REQ,
    input wire logic SYSCALL_REQ,
    input wire logic COP_AV_REQ,
    input wire logic CPU_AV_REQ,
    input wire logic NMI_PIN,
    input wire logic RSTSRC_EXT,
    input wire logic RSTSRC_CLKMON,
    input wire logic RSTSRC_WDOG,
    input wire logic VEC_REQ,
    input wire logic VEC_RESET,
    output logic CPU_IRQ,
    output logic VEC_ACK,
    output logic [15:0] VEC_ADDR,
    output logic [2:0] NEW_LEVEL,
    output logic COPROC_REQ,
    output logic [CH_W-1:0] COPROC_CH,
    output logic COPROC_HIPRI
);
    logic [3:0] cfg [N_CH];
    logic [7:0] vbase;
    logic [6:0] cfg_addr;
    logic [2:0] xprio;
    logic [2:0] rst_cause;
    logic rst_d;
    logic [3:0] pin_s;
    logic nmi_s;
    logic [3*N_CH-1:0] cpu_lv;
    logic [3*N_CH-1:0] cop_lv;
    logic cpu_found;
    logic [CH_W-1:0] cpu_win;
    logic [2:0] cpu_lvl;
    logic cop_found;
    logic [CH_W-1:0] cop_win;
    logic [2:0] cop_lvl;
    logic [7:0] aw_a;
    logic [7:0] wd;
    logic w_lane0;
    logic vec_mask;

    // Pins and reset causes come from other domains
    irq_level_sync #(.W(4)) u_sync (
        .clk(CLK_SYS),
        .d({RSTSRC_WDOG, RSTSRC_CLKMON, RSTSRC_EXT, NMI_PIN}),
        .q(pin_s)
    );
    assign nmi_s = pin_s[0];

    // Per-channel levels presented to each decoder
    always_comb begin
        for (int i = 0; i < N_CH; i++) begin
            logic direct;
            direct = IRQ_REQ[i] && is_cfg(7'(i));
            if (!cfg[i][3]) begin
                cpu_lv[3*i +: 3] = direct ? cfg[i][2:0] : 3'h0;
                cop_lv[3*i +: 3] = 3'h0;
            end else begin
                // Coprocessor-raised CPU requests share one level
                cpu_lv[3*i +: 3] = (COPROC_FLAGS[i] && COPROC_GIE) ? xprio : 3'h0;
                cop_lv[3*i +: 3] = direct ? cfg[i][2:0] : 3'h0;
            end
        end
    end

    // Two independent decoders
    irq_prio_decoder #(.N(N_CH), .IW(CH_W)) u_cpu_dec (
        .levels(cpu_lv),
        .found(cpu_found),
        .win(cpu_win),
        .win_level(cpu_lvl)
    );
    irq_prio_decoder #(.N(N_CH), .IW(CH_W)) u_cop_dec (
        .levels(cop_lv),
        .found(cop_found),
        .win(cop_win),
        .win_level(cop_lvl)
    );

    // CPU qualification and hold-off
    wire cpu_qual = cpu_found && (cpu_lvl > CUR_LEVEL);
    wire nm_pend = TRAP_REQ | SWI_REQ | DEBUG_REQ | SYSCALL_REQ | COP_AV_REQ | CPU_AV_REQ | nmi_s;
    wire next_cpu_irq = cpu_qual && !MASK_FLAG && !nm_pend;

    // Vector choice at the moment of the fetch; non-maskable first
    wire [7:0] next_ofs = TRAP_REQ ? OFS_TRAP :
                          (SWI_REQ | DEBUG_REQ) ? OFS_SWI :
                          SYSCALL_REQ ? OFS_SYS :
                          COP_AV_REQ ? OFS_COP_AV :
                          CPU_AV_REQ ? OFS_CPU_AV :
                          nmi_s ? OFS_NMI :
                          cpu_qual ? {cpu_win, 1'b0} : OFS_SPUR;
    wire next_vec_mask = !nm_pend && cpu_qual;
    // Reset vector by cause; an unknown cause falls back to the external one
    wire [15:0] rst_vec = rst_cause[0] ? VEC_RST_EXT :
                          rst_cause[1] ? VEC_RST_CLKMON :
                          rst_cause[2] ? VEC_RST_WDOG : VEC_RST_EXT;
    wire [15:0] next_vec = VEC_RESET ? rst_vec : {vbase, next_ofs};

    // Reset cause is caught at release, after the synchroniser
    always_ff @(posedge CLK_SYS) begin
        rst_d <= RST;
        if (RST) begin
            rst_cause <= 3'h0;
        end else if (rst_d) begin
            rst_cause <= pin_s[3:1];
        end
    end

    // Vector answer, registered with its acknowledge
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            VEC_ACK <= 1'b0;
            VEC_ADDR <= {VBASE_RST, OFS_SPUR};
            NEW_LEVEL <= 3'h0;
            vec_mask <= 1'b0;
        end else begin
            VEC_ACK <= VEC_REQ;
            if (VEC_REQ) begin
                VEC_ADDR <= next_vec;
                vec_mask <= next_vec_mask && !VEC_RESET;
                // Level only changes for a maskable winner
                NEW_LEVEL <= (next_vec_mask && !VEC_RESET) ? cpu_lvl : CUR_LEVEL;
            end
        end
    end

    // Request lines toward both targets
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            CPU_IRQ <= 1'b0;
            COPROC_REQ <= 1'b0;
            COPROC_CH <= '0;
            COPROC_HIPRI <= 1'b0;
        end else begin
            CPU_IRQ <= next_cpu_irq;
            COPROC_REQ <= cop_found;
            COPROC_CH <= cop_win;
            COPROC_HIPRI <= cop_lvl[2]; // Thread level not consulted
        end
    end

    // Bus write: address and data taken in either order, answered once both held
    wire [7:0] aw_word = {aw_a[7:2], 2'h0};
    wire wr_go = !AWREADY && !WREADY && !BVALID;
    wire wr_ok = is_mapped(aw_word);
    wire wr_do = wr_go && wr_ok && w_lane0;
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
            BVALID <= 1'b0;
            BRESP <= RESP_OKAY;
            aw_a <= 8'h00;
            wd <= 8'h00;
            w_lane0 <= 1'b0;
        end else begin
            if (AWVALID && AWREADY) begin
                AWREADY <= 1'b0;
                aw_a <= AWADDR;
            end
            if (WVALID && WREADY) begin
                WREADY <= 1'b0;
                wd <= WDATA[7:0];
                w_lane0 <= WSTRB[0];
            end
            if (wr_go) begin
                BVALID <= 1'b1;
                BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (BVALID && BREADY) begin
                BVALID <= 1'b0;
                AWREADY <= 1'b1;
                WREADY <= 1'b1;
            end
        end
    end

    // Configuration storage; writes to slots without an entry are dropped
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            vbase <= VBASE_RST;
            cfg_addr <= 7'h00;
            xprio <= XPRIO_RST;
            for (int i = 0; i < N_CH; i++) begin
                cfg[i] <= is_cfg(7'(i)) ? {1'b0, RST_LEVEL} : 4'h0;
            end
        end else if (wr_do) begin
            case (aw_word)
                A_VBASE: vbase <= wd;
                A_CFADDR: cfg_addr <= wd[7:1];
                A_XPRIO: xprio <= wd[2:0];
                A_CFDATA: begin
                    // Spurious and fixed sources have no writable entry
                    if (is_cfg(cfg_addr)) begin
                        cfg[cfg_addr] <= {routable(cfg_addr) & wd[CFG_ROUTE_BIT], wd[2:0]};
                    end
                end
                default: ;
            endcase
        end
    end

    // Read mux; the spurious entry reads as CPU-handled level seven
    wire [7:0] cfg_rd = (cfg_addr == CH_SPUR) ? SPUR_CFG :
                        is_cfg(cfg_addr) ? {cfg[cfg_addr][3], 4'h0, cfg[cfg_addr][2:0]} : 8'h00;
    wire [7:0] ar_word = {ARADDR[7:2], 2'h0};
    wire [7:0] rd_val = (ar_word == A_VBASE) ? vbase :
                        (ar_word == A_CFADDR) ? {cfg_addr, 1'b0} :
                        (ar_word == A_CFDATA) ? cfg_rd :
                        (ar_word == A_XPRIO) ? {5'h00, xprio} :
                        (ar_word == A_STATUS) ? {rst_cause, COPROC_REQ, CPU_IRQ, NEW_LEVEL} : 8'h00;

    // Bus read: one-deep, answer registered on the same edge that takes the address
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ARREADY <= 1'b1;
            RVALID <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= RESP_OKAY;
        end else begin
            if (ARVALID && ARREADY) begin
                ARREADY <= 1'b0;
                RVALID <= 1'b1;
                RDATA <= {24'h00_0000, rd_val};
                RRESP <= is_mapped(ar_word) ? RESP_OKAY : RESP_SLVERR;
            end
            if (RVALID && RREADY) begin
                RVALID <= 1'b0;
                ARREADY <= 1'b1;
            end
        end
    end

    // Checks on the vector and request paths
    wire fetch_mask = VEC_REQ && !VEC_RESET;
    property p_rst_cfg;
        @(posedge CLK_SYS) $fell(RST) |-> cfg[CH_IRQ] == {1'b0, RST_LEVEL};
    endproperty
    a_rst_cfg: assert property (p_rst_cfg) else $error("reset level wrong");
    property p_nmi_vec;
        @(posedge CLK_SYS) disable iff (RST)
        fetch_mask && nmi_s && !TRAP_REQ && !SWI_REQ && !DEBUG_REQ && !SYSCALL_REQ
        && !COP_AV_REQ && !CPU_AV_REQ |=> VEC_ADDR[7:0] == OFS_NMI && NEW_LEVEL == $past(CUR_LEVEL);
    endproperty
    a_nmi_vec: assert property (p_nmi_vec) else $error("pin request vector wrong");
    property p_irq_qual;
        @(posedge CLK_SYS) disable iff (RST)
        CPU_IRQ |-> $past(cpu_lvl) > $past(CUR_LEVEL) && $past(cpu_lvl) != 3'h0;
    endproperty
    a_irq_qual: assert property (p_irq_qual) else $error("request not above level");
    property p_mask_hold;
        @(posedge CLK_SYS) disable iff (RST) (MASK_FLAG || TRAP_REQ) |=> !CPU_IRQ;
    endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("request not held off");
    property p_new_level;
        @(posedge CLK_SYS) disable iff (RST)
        fetch_mask && next_vec_mask |=> VEC_ACK && vec_mask && NEW_LEVEL == $past(cpu_lvl);
    endproperty
    a_new_level: assert property (p_new_level) else $error("level not loaded");
    property p_spur;
        @(posedge CLK_SYS) disable iff (RST)
        fetch_mask && !nm_pend && !cpu_qual |=> VEC_ADDR == {$past(vbase), OFS_SPUR};
    endproperty
    a_spur: assert property (p_spur) else $error("spurious vector wrong");
    property p_rst_vec;
        @(posedge CLK_SYS) disable iff (RST)
        VEC_REQ && VEC_RESET && rst_cause[1] && !rst_cause[0] |=> VEC_ADDR == VEC_RST_CLKMON;
    endproperty
    a_rst_vec: assert property (p_rst_vec) else $error("reset vector wrong");
    property p_hipri;
        @(posedge CLK_SYS) disable iff (RST)
        cop_found && cop_lvl >= 3'h4 |=> COPROC_REQ && COPROC_HIPRI;
    endproperty
    a_hipri: assert property (p_hipri) else $error("coprocessor priority bit wrong");
    property p_ack;
        @(posedge CLK_SYS) disable iff (RST) VEC_REQ |=> VEC_ACK ##1 !VEC_ACK || $past(VEC_REQ);
    endproperty
    a_ack: assert property (p_ack) else $error("vector not acknowledged");
    // Trap outranks every other source at a non-reset fetch
    property p_trap_vec;
        @(posedge CLK_SYS) disable iff (RST)
        fetch_mask && TRAP_REQ |=> VEC_ADDR[7:0] == OFS_TRAP;
    endproperty
    a_trap_vec: assert property (p_trap_vec) else $error("trap vector not first");
    property p_gie_off;
        @(posedge CLK_SYS) disable iff (RST) !COPROC_GIE && IRQ_REQ == '0 |=> !CPU_IRQ;
    endproperty
    a_gie_off: assert property (p_gie_off) else $error("request without enable");
    property p_cop_idle;
        @(posedge CLK_SYS) disable iff (RST) !cop_found |=> !COPROC_REQ;
    endproperty
    a_cop_idle: assert property (p_cop_idle) else $error("stray coprocessor request");
    c_mask_fetch: cover property (@(posedge CLK_SYS) disable iff (RST) fetch_mask && next_vec_mask);
    c_rst_fetch: cover property (@(posedge CLK_SYS) disable iff (RST) VEC_REQ && VEC_RESET);
    c_cop_req: cover property (@(posedge CLK_SYS) disable iff (RST) COPROC_REQ && COPROC_HIPRI);
    c_spur: cover property (@(posedge CLK_SYS) disable iff (RST) fetch_mask && !cpu_qual);
endmodule : interrupt_priority_unit

// file: sim/cpu_vector_model.sv
// CPU-side vector fetch model: pulses a vector request and returns the answer.
// Assumes the unit acknowledges within a few cycles of the request edge.
`timescale 1ns/1ps
module cpu_vector_model (
    input wire logic clk,
    input wire logic vec_ack,
    input wire logic [15:0] vec_addr,
    input wire logic [2:0] new_level,
    output logic vec_req,
    output logic vec_reset
);
    // Idle until the bench asks for a fetch
    initial begin
        vec_req = 1'b0;
        vec_reset = 1'b0;
    end

    // One-cycle request; the bound keeps a silent unit from hanging the run
    task automatic fetch(input logic rkind, output logic [15:0] a, output logic [2:0] l,
                         output logic ok);
        int n;
        ok = 1'b0;
        a = 16'h0000;
        l = 3'h0;
        @(posedge clk);
        vec_req <= 1'b1;
        vec_reset <= rkind;
        @(posedge clk);
        vec_req <= 1'b0;
        vec_reset <= 1'b0;
        for (n = 0; n < 8 && !ok; n++) begin
            @(posedge clk);
            if (vec_ack === 1'b1) begin
                ok = 1'b1;
                a = vec_addr;
                l = new_level;
            end
        end
    endtask : fetch
endmodule : cpu_vector_model

// file: sim/interrupt_priority_unit_tb.sv
// Self-checking bench for the interrupt priority unit.
// Assumes the CPU fetch model beside it; registers are reached over AXI4-Lite.
`timescale 1ns/1ps
module interrupt_priority_unit_tb import irq_prio_pkg::*;;
    logic CLK_SYS, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [7:0] AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA;
    logic [3:0] WSTRB;
    logic [1:0] BRESP, RRESP;
    logic [N_CH-1:0] IRQ_REQ, COPROC_FLAGS;
    logic COPROC_GIE, MASK_FLAG, VEC_REQ, VEC_RESET, CPU_IRQ, VEC_ACK, COPROC_REQ, COPROC_HIPRI;
    logic [2:0] CUR_LEVEL, NEW_LEVEL, rst_cause;
    logic [6:0] nm;
    logic [15:0] VEC_ADDR;
    logic [CH_W-1:0] COPROC_CH;
    logic [7:0] nm_ofs [7] = '{OFS_TRAP, OFS_SWI, OFS_SWI, OFS_SYS, OFS_COP_AV, OFS_CPU_AV, OFS_NMI};
    logic [2:0] rc [5] = '{3'h2, 3'h4, 3'h0, 3'h6, 3'h5};
    logic [15:0] rv [5] = '{16'hFFFC, 16'hFFFA, 16'hFFFE, 16'hFFFC, 16'hFFFE};
    int mismatches, samples_checked, i;

    interrupt_priority_unit dut_u (.CLK_SYS(CLK_SYS), .RST(RST), .AWADDR(AWADDR),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
        .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
        .RREADY(RREADY), .IRQ_REQ(IRQ_REQ), .COPROC_FLAGS(COPROC_FLAGS),
        .COPROC_GIE(COPROC_GIE), .MASK_FLAG(MASK_FLAG), .CUR_LEVEL(CUR_LEVEL),
        .TRAP_REQ(nm[0]), .SWI_REQ(nm[1]), .DEBUG_REQ(nm[2]), .SYSCALL_REQ(nm[3]),
        .COP_AV_REQ(nm[4]), .CPU_AV_REQ(nm[5]), .NMI_PIN(nm[6]), .RSTSRC_EXT(rst_cause[0]),
        .RSTSRC_CLKMON(rst_cause[1]), .RSTSRC_WDOG(rst_cause[2]), .VEC_REQ(VEC_REQ),
        .VEC_RESET(VEC_RESET), .CPU_IRQ(CPU_IRQ), .VEC_ACK(VEC_ACK), .VEC_ADDR(VEC_ADDR),
        .NEW_LEVEL(NEW_LEVEL), .COPROC_REQ(COPROC_REQ), .COPROC_CH(COPROC_CH),
        .COPROC_HIPRI(COPROC_HIPRI));

    cpu_vector_model cpu_u (.clk(CLK_SYS), .vec_ack(VEC_ACK), .vec_addr(VEC_ADDR),
        .new_level(NEW_LEVEL), .vec_req(VEC_REQ), .vec_reset(VEC_RESET));

    // 20 MHz system clock
    initial begin
        CLK_SYS = 1'b0;
        forever #25 CLK_SYS = ~CLK_SYS;
    end

    task automatic give_verdict();
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict

    task automatic hang();
        mismatches++;
        give_verdict();
    endtask : hang

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    // Fetch a vector; level bit 3 set means the level is not compared
    task automatic chk_vec(input logic rk, input logic [15:0] ea, input logic [3:0] el);
        logic [15:0] a;
        logic [2:0] l;
        logic ok;
        cpu_u.fetch(rk, a, l, ok);
        if (ok !== 1'b1) hang();
        chk_val(a, ea);
        if (!el[3]) chk_val(l, el[2:0]);
    endtask : chk_vec

    // Let edges pass, then step off the edge so outputs are settled
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask : tick

    task automatic do_reset(input logic [2:0] c);
        @(posedge CLK_SYS);
        RST <= 1'b1;
        rst_cause <= c;
        repeat (4) @(posedge CLK_SYS);
        RST <= 1'b0;
    endtask : do_reset

    // Address and data offered together, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge CLK_SYS);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge CLK_SYS);
            if (aw && AWREADY === 1'b1) begin
                aw = 1'b0;
                AWVALID <= 1'b0;
            end
            if (w && WREADY === 1'b1) begin
                w = 1'b0;
                WVALID <= 1'b0;
            end
            if (BVALID === 1'b1) begin
                BREADY <= 1'b0;
                chk_val(BRESP, er);
                return;
            end
        end
        hang();
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge CLK_SYS);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge CLK_SYS);
            if (ARREADY === 1'b1) ARVALID <= 1'b0;
            if (RVALID === 1'b1) begin
                RREADY <= 1'b0;
                chk_val(RDATA, ed);
                chk_val(RRESP, er);
                return;
            end
        end
        hang();
    endtask : axi_rd

    // Select a channel entry, then write or read its data byte
    task automatic cfg(input logic [6:0] ch, input logic [7:0] d, input logic rd);
        axi_wr(A_CFADDR, {24'h0, ch, 1'b0}, RESP_OKAY);
        if (rd) axi_rd(A_CFDATA, {24'h0, d}, RESP_OKAY);
        else axi_wr(A_CFDATA, {24'h0, d}, RESP_OKAY);
    endtask : cfg

    initial begin
        mismatches = 0;
        samples_checked = 0;
        {AWVALID, WVALID, BREADY, ARVALID, RREADY, COPROC_GIE, MASK_FLAG} = '0;
        {AWADDR, ARADDR, WDATA} = '0;
        WSTRB = 4'hF;
        {IRQ_REQ, COPROC_FLAGS} = '0;
        CUR_LEVEL = 3'h0;
        nm = 7'h0;
        rst_cause = 3'h1;
        RST = 1'b1;
        do_reset(3'h1);
        axi_rd(A_VBASE, 32'hFF, RESP_OKAY);
        axi_rd(A_XPRIO, 32'h1, RESP_OKAY);
        axi_rd(8'h20, 32'h0, RESP_SLVERR);
        cfg(CH_MASK_LO, 8'h01, 1'b1);
        cfg(CH_IRQ, 8'h01, 1'b1);
        cfg(CH_SPUR, 8'h00, 1'b0);
        cfg(CH_SPUR, SPUR_CFG, 1'b1);
        chk_vec(1'b1, VEC_RST_EXT, 4'h8);
        chk_vec(1'b0, {VBASE_RST, OFS_SPUR}, 4'h0);
        // Equal levels pick the higher channel; raised levels and the current level decide
        @(posedge CLK_SYS);
        IRQ_REQ <= (128'h1 << 'h20) | (128'h1 << 'h30);
        tick(2);
        chk_val(CPU_IRQ, 1'b1);
        chk_vec(1'b0, 16'hFF60, 4'h1);
        cfg(7'h20, 8'h03, 1'b0);
        chk_vec(1'b0, 16'hFF40, 4'h3);
        @(posedge CLK_SYS);
        CUR_LEVEL <= 3'h3;
        tick(2);
        chk_val(CPU_IRQ, 1'b0);
        chk_vec(1'b0, 16'hFF10, 4'h3);
        @(posedge CLK_SYS);
        CUR_LEVEL <= 3'h2;
        chk_vec(1'b0, 16'hFF40, 4'h3);
        @(posedge CLK_SYS);
        CUR_LEVEL <= 3'h0;
        cfg(7'h20, 8'h00, 1'b0);
        cfg(7'h30, 8'h80, 1'b0);
        tick(2);
        chk_val({CPU_IRQ, COPROC_REQ}, 2'b00);
        chk_vec(1'b0, 16'hFF10, 4'h0);
        cfg(7'h30, 8'h01, 1'b0);
        @(posedge CLK_SYS);
        MASK_FLAG <= 1'b1;
        tick(2);
        chk_val(CPU_IRQ, 1'b0);
        @(posedge CLK_SYS);
        MASK_FLAG <= 1'b0;
        // Each non-maskable source beats the pending maskable one
        for (i = 0; i < 7; i++) begin
            @(posedge CLK_SYS);
            nm <= 7'h1 << i;
            tick(5);
            chk_val(CPU_IRQ, 1'b0);
            chk_vec(1'b0, {VBASE_RST, nm_ofs[i]}, 4'h0);
            @(posedge CLK_SYS);
            nm <= 7'h0;
        end
        @(posedge CLK_SYS);
        nm <= 7'h30;
        chk_vec(1'b0, {VBASE_RST, OFS_COP_AV}, 4'h0);
        @(posedge CLK_SYS);
        nm <= 7'h0;
        IRQ_REQ[7'h50] <= 1'b1;
        chk_vec(1'b0, 16'hFFA0, 4'h1);
        // Both decoders busy at once, coprocessor priority bit per level
        @(posedge CLK_SYS);
        IRQ_REQ <= (128'h1 << 'h40) | (128'h1 << 'h30);
        for (i = 1; i < 8; i++) begin
            cfg(7'h40, 8'h80 | 8'(i), 1'b0);
            tick(2);
            chk_val({COPROC_REQ, COPROC_CH, COPROC_HIPRI, CPU_IRQ}, {8'hC0, i[2], 1'b1});
        end
        chk_vec(1'b0, 16'hFF60, 4'h1);
        // Coprocessor-raised CPU requests: route and global enable both needed
        cfg(7'h41, 8'h82, 1'b0);
        axi_rd(A_CFADDR, 32'h82, RESP_OKAY);
        @(posedge CLK_SYS);
        IRQ_REQ <= '0;
        COPROC_FLAGS <= (128'h1 << 'h40) | (128'h1 << 'h41) | (128'h1 << 'h50);
        tick(2);
        chk_val(CPU_IRQ, 1'b0);
        @(posedge CLK_SYS);
        COPROC_GIE <= 1'b1;
        tick(2);
        chk_val(CPU_IRQ, 1'b1);
        chk_vec(1'b0, 16'hFF82, 4'h1);
        axi_wr(A_XPRIO, 32'h4, RESP_OKAY);
        chk_vec(1'b0, 16'hFF82, 4'h4);
        axi_wr(A_VBASE, 32'h12, RESP_OKAY);
        chk_vec(1'b0, 16'h1282, 4'h4);
        // A write without the low byte lane is taken but changes nothing
        @(posedge CLK_SYS);
        WSTRB <= 4'hE;
        axi_wr(A_VBASE, 32'h34, RESP_OKAY);
        WSTRB <= 4'hF;
        axi_rd(A_VBASE, 32'h12, RESP_OKAY);
        axi_wr(8'h24, 32'h0, RESP_SLVERR);
        // Reset causes and their fixed vectors
        for (i = 0; i < 5; i++) begin
            do_reset(rc[i]);
            chk_vec(1'b1, rv[i], 4'h8);
        end
        axi_rd(A_STATUS, 32'hA0, RESP_OKAY);
        chk_vec(1'b0, {VBASE_RST, OFS_SPUR}, 4'h0);
        give_verdict();
    end
endmodule : interrupt_priority_unit_tb
